// ===== hw/hbr_pkg.sv
// package: constants and types for the host-bus dual-select read engine
package hbr_pkg;
	localparam logic [1:0] HBR_SELECT_CONFIG_FIELD_DUAL  = 2'h2;
	localparam logic [1:0] HBR_MODE_CONT   = 2'h2;
	localparam logic [3:0] HBR_READ_WAIT_STATES_MIN    = 4'h0;
	localparam int         HBR_BASE_WIDTH  = 2;
	localparam int         HBR_WS_STEP     = 2;
	localparam int         HBR_CNT_W       = 6;
	localparam logic [5:0] HBR_CNT_ONE     = 6'h01;

	typedef enum logic [1:0] {
		HBR_IDLE  = 2'b00,
		HBR_WRONG = 2'b01,
		HBR_RIGHT = 2'b10,
		HBR_HOLD  = 2'b11
	} hbr_state_t;
endpackage

// ===== hw/hbr_if.sv
// interface: strobe width request and answer between engine and width counter
`timescale 1ns/100ps
interface hbr_if;
	logic       load;
	logic [5:0] width;
	logic       done;
	modport engine (output load, output width, input done);
	modport timer  (input load, input width, output done);
endinterface

// ===== hw/hbr_width_timer.sv
// module: counts the programmed read strobe width in bus clocks
`timescale 1ns/100ps
module hbr_width_timer
	import hbr_pkg::*;
(
	// clock and reset
	input  wire logic core_clk,
	input  wire logic sys_rst,
	// link to engine
	hbr_if.timer      tmr
);
	logic [HBR_CNT_W-1:0] cnt_reg;
	logic [HBR_CNT_W-1:0] cnt_next;
	logic                 done_reg;

	// counter reloads on load, otherwise counts down to one
	assign cnt_next = tmr.load ? tmr.width :
		(cnt_reg > HBR_CNT_ONE) ? cnt_reg - HBR_CNT_ONE : cnt_reg;
	assign tmr.done = done_reg;

	// done marks the last strobe clock
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cnt_reg  <= '0;
			done_reg <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			done_reg <= tmr.load ? (tmr.width == HBR_CNT_ONE) : (cnt_next == HBR_CNT_ONE);
		end
	end
endmodule

// ===== hw/hbr_read_engine.sv
// module: read strobe and chip-select generation, dual-select continuous read
`timescale 1ns/100ps
module hbr_read_engine
	import hbr_pkg::*;
#(
	parameter int DATA_W = 16
)
(
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              sys_rst,
	// configuration
	input  wire logic              host_bus_mode,
	input  wire logic [1:0]        select_config_field,
	input  wire logic [1:0]        bus_mode_field,
	input  wire logic [3:0]        read_wait_states,
	// read request from core
	input  wire logic              rd_req,
	input  wire logic              rd_region,
	input  wire logic              oe_active,
	output logic                   rd_busy,
	output logic                   rd_valid,
	output logic [DATA_W-1:0]      rd_data,
	// bus pins
	input  wire logic [DATA_W-1:0] bus_data_in,
	output logic                   read_strobe_low,
	output logic                   select_zero_low,
	output logic                   select_one_low
);
	// ==========================================
	// usage notes
	// zero wait states leave no room for the two-flop data path on any read:
	// data then come from the bus as it stood before the strobe, so software
	// keeps the wait-state field at one step or more in every setting

	// ==========================================
	// elaboration checks
	// widest strobe that the wait-state field can ask for
	localparam int WIDTH_MAX = HBR_BASE_WIDTH +
		HBR_WS_STEP * (2 ** $bits(read_wait_states) - 1);

	// the counter must hold the widest strobe, and the strobe must outlast
	// the one clock spent under the wrong select
	initial begin
		if (DATA_W < 1 || DATA_W > 32) $error("DATA_W out of range");
		if (WIDTH_MAX >= 2 ** HBR_CNT_W) $error("strobe counter too narrow");
		if (HBR_BASE_WIDTH <= int'(HBR_CNT_ONE)) $error("strobe too short for the swap");
	end

	// ==========================================
	// width timer
	// the strobe width is counted apart from the state machine, so the
	// wrong-select clock of a first read is charged against the same count;
	// the timer reloads on every taken request and needs no clear of its own
	hbr_if tif ();

	hbr_width_timer u_tmr (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.tmr      (tif)
	);

	// ==========================================
	// pin sampling
	// bus data come from outside the clock domain: every bit passes two flops
	// before it is read; the cost is that the peripheral must drive valid data
	// at least two clocks before the strobe ends
	logic [DATA_W-1:0] din_s1_reg;
	logic [DATA_W-1:0] din_s2_reg;

	// one synchroniser per data bit
	for (genvar gi = 0; gi < DATA_W; gi++) begin : g_sync
		always_ff @(posedge core_clk) begin
			din_s1_reg[gi] <= bus_data_in[gi];
			din_s2_reg[gi] <= din_s1_reg[gi];
		end
	end

	// ==========================================
	// configuration decode
	hbr_state_t state_reg;
	hbr_state_t state_next;
	logic       first_done_reg;
	logic       first_done_next;
	logic       region_reg;
	logic       region_now;
	logic       host_bus_dual;
	logic       cont_read;
	logic       faulty;
	logic       first_read;
	logic       start;
	logic       read_end;
	logic [5:0] width;

	// the wrong-select first read needs all three settings at once
	assign host_bus_dual = host_bus_mode && select_config_field == HBR_SELECT_CONFIG_FIELD_DUAL;
	assign cont_read     = bus_mode_field == HBR_MODE_CONT;
	assign faulty        = host_bus_dual && cont_read;

	// a read counts as first unless one has ended while output enable stayed
	// held; enable is read live, so a read taken as it drops is first again
	assign first_read = !(first_done_reg && oe_active);

	// strobe width in clocks, charged from the first strobe clock
	assign width = 6'(HBR_BASE_WIDTH) + 6'(HBR_WS_STEP) * {2'h0, read_wait_states};

	// ==========================================
	// request taking
	// a request is taken only from idle; one raised while busy is not stored
	assign start      = rd_req && state_reg == HBR_IDLE;
	assign read_end   = state_reg != HBR_IDLE && state_next == HBR_IDLE;
	assign region_now = start ? rd_region : region_reg;
	assign tif.load   = start;
	assign tif.width  = width;

	// first-read flag: set when a read ends under enable, cleared when it drops
	assign first_done_next = !oe_active ? 1'b0 :
		read_end ? 1'b1 : first_done_reg;

	// ==========================================
	// state machine
	// a faulty first read spends exactly one clock under the wrong select,
	// then runs under the right one until the timer reports the last clock
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			HBR_IDLE: begin
				if (rd_req && faulty && first_read) begin
					state_next = HBR_WRONG;
				end else if (rd_req) begin
					state_next = HBR_RIGHT;
				end
			end
			HBR_WRONG: begin
				// the swap comes on the next edge whatever the width
				state_next = tif.done ? HBR_IDLE : HBR_RIGHT;
			end
			HBR_RIGHT: begin
				state_next = tif.done ? HBR_IDLE : HBR_RIGHT;
			end
			default: begin
				// the spare code is never entered; it falls back to idle
				state_next = HBR_IDLE;
			end
		endcase
	end

	// ==========================================
	// pin decode
	// the strobe is one continuous pulse across the swap; the select that
	// drives is the request's region, flipped while in the wrong state
	logic strobe_on;
	logic wrong_on;
	logic drive_one;
	logic zero_on;
	logic one_on;

	assign strobe_on = state_next != HBR_IDLE;
	assign wrong_on  = state_next == HBR_WRONG;
	assign drive_one = region_now ^ wrong_on;
	assign zero_on   = strobe_on && !drive_one;
	assign one_on    = strobe_on && drive_one;

	// ==========================================
	// registers
	// state and read bookkeeping
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_reg      <= HBR_IDLE;
			first_done_reg <= 1'b0;
			region_reg     <= 1'b0;
		end else begin
			state_reg      <= state_next;
			first_done_reg <= first_done_next;
			region_reg     <= region_now;
		end
	end

	// bus pins, all idle high; the select swap lands on a clock edge
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			read_strobe_low <= 1'b1;
			select_zero_low <= 1'b1;
			select_one_low  <= 1'b1;
		end else begin
			read_strobe_low <= !strobe_on;
			select_zero_low <= !zero_on;
			select_one_low  <= !one_on;
		end
	end

	// ==========================================
	// core side
	// busy follows the strobe; valid pulses on the clock the strobe ends,
	// so the core sees data and valid together
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rd_busy  <= 1'b0;
			rd_valid <= 1'b0;
		end else begin
			rd_busy  <= strobe_on;
			rd_valid <= read_end;
		end
	end

	// capture on the last strobe clock; data hold until the next read
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rd_data <= '0;
		end else if (read_end) begin
			rd_data <= din_s2_reg;
		end
	end
endmodule

// ===== test/hbr_periph.sv
// partner: memory on two select regions
`timescale 1ns/100ps
module hbr_periph (
	// pins
	input  wire logic        core_clk,
	input  wire logic        read_strobe_low,
	input  wire logic        select_zero_low,
	input  wire logic        select_one_low,
	output logic      [15:0] bus_data_in
);
	logic [15:0] last_reg;
	// released bus inverts last value, so stale data cannot pass
	assign bus_data_in = (!read_strobe_low && !select_zero_low) ? 16'h5AC3 :
		(!read_strobe_low && !select_one_low) ? 16'hC35A : ~last_reg;
	always_ff @(posedge core_clk) begin
		last_reg <= bus_data_in;
	end
endmodule

// ===== test/hbr_read_monitor.sv
// checker: pin timing of the read engine
`timescale 1ns/100ps
module hbr_read_monitor
	import hbr_pkg::*;
(
	// clock, config, pins
	input wire logic       core_clk,
	input wire logic       sys_rst,
	input wire logic       host_bus_mode,
	input wire logic [1:0] select_config_field,
	input wire logic [1:0] bus_mode_field,
	input wire logic [3:0] read_wait_states,
	input wire logic       rd_region,
	input wire logic       oe_active,
	input wire logic       rd_busy,
	input wire logic       rd_valid,
	input wire logic       read_strobe_low,
	input wire logic       select_zero_low,
	input wire logic       select_one_low
);
	logic [5:0] cnt_reg;
	logic       oe_prev_reg;
	logic       ended_reg;
	logic       dual_cont;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// the setting in which the first read goes out under the wrong select
	assign dual_cont = host_bus_mode && select_config_field == HBR_SELECT_CONFIG_FIELD_DUAL &&
		bus_mode_field == HBR_MODE_CONT;
	// strobe-low cycle count
	always_ff @(posedge core_clk) begin
		cnt_reg <= (sys_rst || read_strobe_low) ? 6'h00 : cnt_reg + 6'h01;
	end
	// a read has ended with output enable held on its last clock and since
	always_ff @(posedge core_clk) begin
		oe_prev_reg <= oe_active;
		if (sys_rst || !oe_active)
			ended_reg <= 1'b0;
		else if (rd_valid && oe_prev_reg)
			ended_reg <= 1'b1;
	end
	a_one_select: assert property ($fell(read_strobe_low) |-> select_zero_low ^ select_one_low)
		else $error("strobe start select");
	a_never_both: assert property (select_zero_low || select_one_low)
		else $error("both selects low");
	a_swap_edge: assert property (!read_strobe_low && $rose(select_one_low) |-> !select_zero_low)
		else $error("swap edge");
	a_swap_zero: assert property (!read_strobe_low && $rose(select_zero_low) |-> !select_one_low)
		else $error("swap edge region one");
	a_busy_strobe: assert property (rd_busy == !read_strobe_low)
		else $error("busy vs strobe");
	a_zero_wait: assert property ($fell(read_strobe_low)
		&& read_wait_states == HBR_READ_WAIT_STATES_MIN |=> !read_strobe_low ##1 read_strobe_low)
		else $error("zero wait width");
	a_strobe_width: assert property ($rose(read_strobe_low)
		|-> cnt_reg == 6'(HBR_BASE_WIDTH + HBR_WS_STEP * $past(read_wait_states)))
		else $error("strobe width");
	a_valid_end: assert property (rd_valid == $rose(read_strobe_low))
		else $error("valid timing");
	a_right_sel: assert property ($fell(read_strobe_low) && !dual_cont
		|-> select_zero_low == $past(rd_region))
		else $error("select region");
	a_first_select: assert property ($fell(read_strobe_low) && dual_cont
		|-> select_zero_low == ($past(rd_region) ^ !ended_reg))
		else $error("first read select");
	a_swap_once: assert property ($fell(read_strobe_low) && dual_cont && !ended_reg
		|=> select_zero_low == $past(rd_region, 2) && select_one_low == !$past(rd_region, 2))
		else $error("wrong select held");
endmodule
bind hbr_read_engine hbr_read_monitor u_mon (.*);

// ===== test/tb_top.sv
// testbench: read engine against two-region memory
`timescale 1ns/100ps
module tb_top;
	logic        core_clk, sys_rst, host_bus_mode, rd_req, rd_region, oe_active, rd_busy, rd_valid;
	logic        read_strobe_low, select_zero_low, select_one_low;
	logic [1:0]  select_config_field, bus_mode_field;
	logic [3:0]  read_wait_states;
	logic [15:0] rd_data, bus_data_in;
	logic [16:0] exp_q[$], e;
	int          fail_count = 0, checked = 0, seed = 32'h5491, i;
	always #25 core_clk = ~core_clk;
	hbr_read_engine DUT (.*);
	hbr_periph u_mem (.*);
	task automatic finish_test;
		$display("fail_count=%0d checked=%0d", fail_count, checked);
		if (fail_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// watcher: oldest note against each valid pulse
	always @(negedge core_clk) begin
		if (rd_valid === 1'b1) begin
			e = exp_q.pop_front();
			checked += e[16];
			if (e[16] && rd_data !== e[15:0]) begin
				fail_count++;
				$display("wrong value at %0t: read data %h", $time, rd_data);
			end
		end
	end
	// driver: every config mix, oe dropped each fourth read to re-arm the first read
	initial begin
		{core_clk, sys_rst, host_bus_mode, rd_req, rd_region, oe_active} = 6'h11;
		{select_config_field, bus_mode_field, read_wait_states} = 8'h00;
		repeat (3) @(negedge core_clk);
		sys_rst = 0;
		for (int k = 0; k < 64; k++) begin
			host_bus_mode = k[3:2] != 2'h0;
			select_config_field = k[4] ? 2'h1 : 2'h2;
			bus_mode_field = k[5] ? 2'h0 : 2'h2;
			oe_active = k[1:0] != 2'h0;
			read_wait_states = 4'({$random(seed)} % 3);
			rd_region = 1'($random(seed));
			rd_req = 1;
			// zero wait states leave no margin, so data is judged only when widened
			exp_q.push_back({read_wait_states != 4'h0, rd_region ? 16'hC35A : 16'h5AC3});
			@(negedge core_clk);
			rd_req = 0;
			for (i = 0; i < 40 && rd_valid !== 1'b1; i++) @(negedge core_clk);
			if (i == 40) begin
				fail_count++;
				finish_test();
			end
		end
		finish_test();
	end
endmodule
